// ### src/sbf_pkg.sv
// Package of constants, types and helpers for the servo I/O function, brake and filter block
// Behaviour
// - Brake mode 1: brake pin closed while enabled, open while disabled.
// - Brake mode 2: brake pin open while enabled, closed while disabled.
// - Brake mode 3: brake pin is a general purpose output.
// - Output select holds four digits for Y3..Y6 from the right, reset 413d.
// - Y3 digit 8 closes, digit 9 opens, when torque reaches target.
// - Y4 digit 6 closes, digit 7 opens, while position error within window.
// - Y4 digit a closes, digit b opens, when velocity reaches target.
// - Y5 digit 1 closes, digit 2 opens, while the drive is enabled.
// - Y6 digit 4 closes, digit 5 opens, when motion completes in position.
// - Y6 digit c gives tachometer pulses while the motor runs.
// - Digit 3 makes Y3..Y6 a general purpose output.
// - Release and apply delays act only in brake modes 1 and 2.
// - Enable sets brake, starts millisecond release countdown, blocks moves until expiry.
// - Disable switches brake at once, keeps current on for apply delay.
// - Filtered input updates after the pin is stable for count 250 us cycles.
// - A filter count of zero bypasses the debounce.
// - Inputs X9..X12 each have an independent filter count.
package sbf_pkg;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int FILTER_TICK_NS = 250000;
  localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_CYCLES    = FILTER_TICK_NS / CLK_PERIOD_NS;
  localparam int PRESC_W        = 17;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_MOTION_SEL  = 4'h0;
  localparam logic [3:0] ADDR_BRAKE_MODE  = 4'h1;
  localparam logic [3:0] ADDR_RELEASE_DLY = 4'h2;
  localparam logic [3:0] ADDR_APPLY_DLY   = 4'h3;
  localparam logic [3:0] ADDR_FILTER_A    = 4'h4;
  localparam logic [3:0] ADDR_FILTER_D    = 4'h7;
  localparam logic [3:0] ADDR_GP_OUT      = 4'h8;
  localparam logic [3:0] ADDR_STATUS      = 4'h9;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'ha;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'hb;
  localparam logic [15:0] RST_MOTION_SEL  = 16'h413d;
  localparam logic [1:0]  RST_BRAKE_MODE  = 2'h1;
  localparam logic [15:0] RST_DELAY       = 16'h00c8;
  localparam logic [14:0] RST_FILTER      = 15'h0000;
  // ---------------------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] BRAKE_MODE_ON_EN  = 2'h1;
  localparam logic [1:0] BRAKE_MODE_OFF_EN = 2'h2;
  localparam logic [3:0] DIG_EN_CLOSE  = 4'h1;
  localparam logic [3:0] DIG_EN_OPEN   = 4'h2;
  localparam logic [3:0] DIG_INPOS_CLOSE = 4'h4;
  localparam logic [3:0] DIG_INPOS_OPEN  = 4'h5;
  localparam logic [3:0] DIG_WIN_CLOSE = 4'h6;
  localparam logic [3:0] DIG_WIN_OPEN  = 4'h7;
  localparam logic [3:0] DIG_TRQ_CLOSE = 4'h8;
  localparam logic [3:0] DIG_TRQ_OPEN  = 4'h9;
  localparam logic [3:0] DIG_VEL_CLOSE = 4'ha;
  localparam logic [3:0] DIG_VEL_OPEN  = 4'hb;
  localparam logic [3:0] DIG_TACH      = 4'hc;
  localparam int IRQ_W = 6;

  typedef struct packed {
    logic torque_reached;
    logic pos_in_window;
    logic vel_reached;
    logic in_position;
    logic running;
    logic tach_pulse;
  } sbf_motion_t;

  typedef struct packed {
    logic brake;
    logic torque;
    logic pos_vel;
    logic enabled;
    logic in_pos_tach;
  } sbf_pins_t;

  // Digit equal to close code follows cond, open code inverts it, else fallback
  function automatic logic sbf_map_level(input logic [3:0] digit, input logic [3:0] close_code,
                                         input logic [3:0] open_code, input logic cond,
                                         input logic fallback);
    if (digit == close_code) return cond;
    if (digit == open_code) return ~cond;
    return fallback;
  endfunction : sbf_map_level
endpackage : sbf_pkg

// ### src/sbf_debounce.sv
// Debounce filter for one synchronised input
`timescale 1ns/1ps
`default_nettype none
module sbf_debounce (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        tick_in,
  input  wire logic [14:0] count_in,
  input  wire logic        level_in,
  output logic             state_out
);
  logic        state;
  logic        pending;
  logic [14:0] cnt;
  logic        next_state;
  logic        next_pending;
  logic [14:0] next_cnt;

  always_comb begin
    next_state   = state;
    next_pending = pending;
    next_cnt     = cnt;
    if (count_in == 15'h0000) begin
      next_state   = level_in;
      next_pending = level_in;
      next_cnt     = 15'h0000;
    end else if (level_in != pending) begin
      next_pending = level_in;
      next_cnt     = 15'h0000;
    end else if (pending != state && tick_in) begin
      next_cnt = cnt + 15'h0001;
      if (next_cnt >= count_in) begin
        next_state = pending;
        next_cnt   = 15'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state   <= 1'b0;
      pending <= 1'b0;
      cnt     <= 15'h0000;
    end else begin
      state   <= next_state;
      pending <= next_pending;
      cnt     <= next_cnt;
    end
  end

  assign state_out = state;
endmodule : sbf_debounce
`default_nettype wire

// ### src/sbf_brake_seq.sv
// Brake release and apply sequencer with millisecond countdown
`timescale 1ns/1ps
`default_nettype none
module sbf_brake_seq #(
  parameter int MS_CYCLES = sbf_pkg::MS_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        delays_on_in,
  input  wire logic        enable_in,
  input  wire logic [15:0] release_dly_in,
  input  wire logic [15:0] apply_dly_in,
  output logic             move_permit_out,
  output logic             current_on_out,
  output logic             release_done_out,
  output logic             apply_done_out
);
  typedef enum logic [1:0] {SBF_OFF, SBF_RELEASE, SBF_RUN, SBF_APPLY} sbf_bstate_t;
  sbf_bstate_t                     st, next_st;
  logic [15:0]                     cnt, next_cnt;
  logic [sbf_pkg::PRESC_W-1:0]     presc, next_presc;
  logic                            rel_pulse, app_pulse, next_rel, next_app;
  logic                            ms_tick;

  assign ms_tick = (presc == sbf_pkg::PRESC_W'(MS_CYCLES - 1));

  always_comb begin
    next_st    = st;
    next_cnt   = cnt;
    next_presc = ms_tick ? '0 : presc + 1'b1;
    next_rel   = 1'b0;
    next_app   = 1'b0;
    unique case (st)
      SBF_OFF, SBF_APPLY: begin
        if (enable_in) begin
          // Prescaler restarts so the first millisecond is a whole one
          next_presc = '0;
          if (delays_on_in && release_dly_in != 16'h0000) begin
            next_st  = SBF_RELEASE;
            next_cnt = release_dly_in;
          end else begin
            next_st  = SBF_RUN;
            next_rel = 1'b1;
          end
        end else if (st == SBF_APPLY && ms_tick) begin
          next_cnt = cnt - 16'h0001;
          if (cnt == 16'h0001) begin
            next_st  = SBF_OFF;
            next_app = 1'b1;
          end
        end
      end
      SBF_RELEASE, SBF_RUN: begin
        if (!enable_in) begin
          next_presc = '0;
          if (delays_on_in && apply_dly_in != 16'h0000) begin
            next_st  = SBF_APPLY;
            next_cnt = apply_dly_in;
          end else begin
            next_st  = SBF_OFF;
            next_app = 1'b1;
          end
        end else if (st == SBF_RELEASE && ms_tick) begin
          next_cnt = cnt - 16'h0001;
          if (cnt == 16'h0001) begin
            next_st  = SBF_RUN;
            next_rel = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st        <= SBF_OFF;
      cnt       <= 16'h0000;
      presc     <= '0;
      rel_pulse <= 1'b0;
      app_pulse <= 1'b0;
    end else begin
      st        <= next_st;
      cnt       <= next_cnt;
      presc     <= next_presc;
      rel_pulse <= next_rel;
      app_pulse <= next_app;
    end
  end

  assign move_permit_out  = (st == SBF_RUN);
  assign current_on_out   = (st != SBF_OFF);
  assign release_done_out = rel_pulse;
  assign apply_done_out   = app_pulse;
endmodule : sbf_brake_seq
`default_nettype wire

// ### src/sbf_top.sv
// Top of the servo I/O function, brake and input filter block
`timescale 1ns/1ps
`default_nettype none
module sbf_top #(
  parameter int MS_CYCLES   = sbf_pkg::MS_CYCLES,
  parameter int TICK_CYCLES = sbf_pkg::TICK_CYCLES
) (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_n_in,
  // Register port
  input  wire logic [3:0]          reg_addr_in,
  input  wire logic [15:0]         reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [15:0]         reg_rdata_out,
  // Motion controller side
  input  wire logic                drive_enable_in,
  input  wire sbf_pkg::sbf_motion_t motion_in,
  output logic                     move_permit_out,
  output logic                     motor_current_on_out,
  output logic      [3:0]          filtered_inputs_out,
  // Pins
  input  wire logic                filtered_input_a_in,
  input  wire logic                filtered_input_b_in,
  input  wire logic                filtered_input_c_in,
  input  wire logic                filtered_input_d_in,
  output sbf_pkg::sbf_pins_t       pins_out,
  output logic                     irq_out
);
  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [15:0]                motion_output_select, next_motion_output_select;
  logic [1:0]                 brake_output_mode, next_brake_output_mode;
  logic [15:0]                brake_release_delay, next_brake_release_delay;
  logic [15:0]                brake_apply_delay, next_brake_apply_delay;
  logic [3:0][14:0]           input_debounce_count, next_input_debounce_count;
  logic [4:0]                 gp_out, next_gp_out;
  logic [sbf_pkg::IRQ_W-1:0]  irq_status, next_irq_status;
  logic [sbf_pkg::IRQ_W-1:0]  irq_mask, next_irq_mask;
  logic [15:0]                rdata, next_rdata;
  logic [sbf_pkg::IRQ_W-1:0]  events;
  logic [3:0]                 fidx;
  logic                       filt_sel;

  // ---------------------------------------------------------------------------
  // Input synchronisers and filter tick
  // ---------------------------------------------------------------------------
  logic [3:0]                 raw_pins;
  logic [3:0]                 sync1, sync2, sync3;
  logic [3:0]                 sync_level, next_sync_level;
  logic [3:0]                 filt_state, filt_prev;
  logic [sbf_pkg::PRESC_W-1:0] tick_cnt, next_tick_cnt;
  logic                       tick;

  assign raw_pins = {filtered_input_d_in, filtered_input_c_in,
                     filtered_input_b_in, filtered_input_a_in};
  assign tick     = (tick_cnt == sbf_pkg::PRESC_W'(TICK_CYCLES - 1));

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    // A pin change counts only once the second and third stages agree
    for (int i = 0; i < 4; i++) begin
      next_sync_level[i] = (sync2[i] == sync3[i]) ? sync3[i] : sync_level[i];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync1      <= 4'h0;
      sync2      <= 4'h0;
      sync3      <= 4'h0;
      sync_level <= 4'h0;
      tick_cnt   <= '0;
      filt_prev  <= 4'h0;
    end else begin
      sync1      <= raw_pins;
      sync2      <= sync1;
      sync3      <= sync2;
      sync_level <= next_sync_level;
      tick_cnt   <= next_tick_cnt;
      filt_prev  <= filt_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Debounce filters
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      sbf_debounce u_filt (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .tick_in    (tick),
        .count_in   (input_debounce_count[g]),
        .level_in   (sync_level[g]),
        .state_out  (filt_state[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Brake sequencing
  // ---------------------------------------------------------------------------
  logic delays_on;
  logic release_done;
  logic apply_done;

  assign delays_on = (brake_output_mode == sbf_pkg::BRAKE_MODE_ON_EN) ||
                     (brake_output_mode == sbf_pkg::BRAKE_MODE_OFF_EN);

  sbf_brake_seq #(
    .MS_CYCLES (MS_CYCLES)
  ) u_brake (
    .sys_clk_in       (sys_clk_in),
    .rst_n_in         (rst_n_in),
    .delays_on_in     (delays_on),
    .enable_in        (drive_enable_in),
    .release_dly_in   (brake_release_delay),
    .apply_dly_in     (brake_apply_delay),
    .move_permit_out  (move_permit_out),
    .current_on_out   (motor_current_on_out),
    .release_done_out (release_done),
    .apply_done_out   (apply_done)
  );

  // ---------------------------------------------------------------------------
  // Output pin mapping
  // ---------------------------------------------------------------------------
  sbf_pkg::sbf_pins_t pins, next_pins;
  logic [3:0]         dig_trq, dig_pv, dig_en, dig_ip;

  // Digits read from the right: Y3, Y4, Y5, Y6
  assign dig_trq = motion_output_select[3:0];
  assign dig_pv  = motion_output_select[7:4];
  assign dig_en  = motion_output_select[11:8];
  assign dig_ip  = motion_output_select[15:12];

  always_comb begin
    // In brake modes 1 and 2 the brake pin follows the enable command at once; release delay only gates moves, apply delay only current
    unique case (brake_output_mode)
      sbf_pkg::BRAKE_MODE_ON_EN:  next_pins.brake = drive_enable_in;
      sbf_pkg::BRAKE_MODE_OFF_EN: next_pins.brake = ~drive_enable_in;
      default:                    next_pins.brake = gp_out[0];
    endcase
    next_pins.torque = sbf_pkg::sbf_map_level(dig_trq, sbf_pkg::DIG_TRQ_CLOSE,
                         sbf_pkg::DIG_TRQ_OPEN, motion_in.torque_reached, gp_out[1]);
    next_pins.pos_vel = sbf_pkg::sbf_map_level(dig_pv, sbf_pkg::DIG_WIN_CLOSE,
                          sbf_pkg::DIG_WIN_OPEN, motion_in.pos_in_window,
                          sbf_pkg::sbf_map_level(dig_pv, sbf_pkg::DIG_VEL_CLOSE,
                            sbf_pkg::DIG_VEL_OPEN, motion_in.vel_reached, gp_out[2]));
    next_pins.enabled = sbf_pkg::sbf_map_level(dig_en, sbf_pkg::DIG_EN_CLOSE,
                          sbf_pkg::DIG_EN_OPEN, drive_enable_in, gp_out[3]);
    if (dig_ip == sbf_pkg::DIG_TACH) begin
      next_pins.in_pos_tach = motion_in.running & motion_in.tach_pulse;
    end else begin
      next_pins.in_pos_tach = sbf_pkg::sbf_map_level(dig_ip, sbf_pkg::DIG_INPOS_CLOSE,
                                sbf_pkg::DIG_INPOS_OPEN, motion_in.in_position, gp_out[4]);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  assign pins_out            = pins;
  assign filtered_inputs_out = filt_state;

  // ---------------------------------------------------------------------------
  // Register file and interrupts
  // ---------------------------------------------------------------------------
  // Events: four filtered input edges, release done, apply done
  assign events   = {apply_done, release_done, filt_state ^ filt_prev};
  assign fidx     = reg_addr_in - sbf_pkg::ADDR_FILTER_A;
  assign filt_sel = (reg_addr_in >= sbf_pkg::ADDR_FILTER_A) &&
                    (reg_addr_in <= sbf_pkg::ADDR_FILTER_D);

  always_comb begin
    next_motion_output_select = motion_output_select;
    next_brake_output_mode    = brake_output_mode;
    next_brake_release_delay  = brake_release_delay;
    next_brake_apply_delay    = brake_apply_delay;
    next_input_debounce_count = input_debounce_count;
    next_gp_out               = gp_out;
    next_irq_mask             = irq_mask;
    next_rdata                = 16'h0000;
    next_irq_status           = irq_status;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        sbf_pkg::ADDR_MOTION_SEL:  next_motion_output_select = reg_wdata_in;
        sbf_pkg::ADDR_BRAKE_MODE:  next_brake_output_mode = reg_wdata_in[1:0];
        sbf_pkg::ADDR_RELEASE_DLY: next_brake_release_delay = reg_wdata_in;
        sbf_pkg::ADDR_APPLY_DLY:   next_brake_apply_delay = reg_wdata_in;
        sbf_pkg::ADDR_GP_OUT:      next_gp_out = reg_wdata_in[4:0];
        sbf_pkg::ADDR_IRQ_MASK:    next_irq_mask = reg_wdata_in[sbf_pkg::IRQ_W-1:0];
        default: begin
          if (filt_sel) begin
            next_input_debounce_count[fidx[1:0]] = reg_wdata_in[14:0];
          end
        end
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        sbf_pkg::ADDR_MOTION_SEL:  next_rdata = motion_output_select;
        sbf_pkg::ADDR_BRAKE_MODE:  next_rdata = {14'h0000, brake_output_mode};
        sbf_pkg::ADDR_RELEASE_DLY: next_rdata = brake_release_delay;
        sbf_pkg::ADDR_APPLY_DLY:   next_rdata = brake_apply_delay;
        sbf_pkg::ADDR_GP_OUT:      next_rdata = {11'h000, gp_out};
        sbf_pkg::ADDR_STATUS:      next_rdata = {4'h0, pins, motor_current_on_out,
                                                 move_permit_out, drive_enable_in, filt_state};
        sbf_pkg::ADDR_IRQ_STATUS: begin
          next_rdata      = {10'h000, irq_status};
          next_irq_status = '0;
        end
        sbf_pkg::ADDR_IRQ_MASK:    next_rdata = {10'h000, irq_mask};
        default: begin
          if (filt_sel) begin
            next_rdata = {1'b0, input_debounce_count[fidx[1:0]]};
          end
        end
      endcase
    end
    // A new event in the clearing cycle survives the read
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      motion_output_select <= sbf_pkg::RST_MOTION_SEL;
      brake_output_mode    <= sbf_pkg::RST_BRAKE_MODE;
      brake_release_delay  <= sbf_pkg::RST_DELAY;
      brake_apply_delay    <= sbf_pkg::RST_DELAY;
      input_debounce_count <= {4{sbf_pkg::RST_FILTER}};
      gp_out               <= 5'h00;
      irq_status           <= '0;
      irq_mask             <= '0;
      rdata                <= 16'h0000;
    end else begin
      motion_output_select <= next_motion_output_select;
      brake_output_mode    <= next_brake_output_mode;
      brake_release_delay  <= next_brake_release_delay;
      brake_apply_delay    <= next_brake_apply_delay;
      input_debounce_count <= next_input_debounce_count;
      gp_out               <= next_gp_out;
      irq_status           <= next_irq_status;
      irq_mask             <= next_irq_mask;
      rdata                <= next_rdata;
    end
  end

  assign reg_rdata_out = rdata;
  assign irq_out       = |(irq_status & irq_mask);
endmodule : sbf_top
`default_nettype wire

// ### verification/sbf_checker.sv
// Checker of brake, output select and read port timing
`timescale 1ns/1ps
`default_nettype none
module sbf_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic                 sys_clk_in,
  input wire logic                 rst_n_in,
  input wire logic [3:0]           reg_addr_in,
  input wire logic [15:0]          reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [15:0]          reg_rdata_out,
  input wire logic                 drive_enable_in,
  input wire sbf_pkg::sbf_motion_t motion_in,
  input wire logic                 move_permit_out,
  input wire logic                 motor_current_on_out,
  input wire sbf_pkg::sbf_pins_t   pins_out
);
  // Shadow copies let the checks follow register writes without seeing inside
  localparam int T_LO = 2 * MS_CYCLES - 4;
  logic [1:0]  mode;
  logic [15:0] sel;
  logic [15:0] rel;
  logic [15:0] app;
  logic        live;
  always_ff @(posedge sys_clk_in) begin
    live <= rst_n_in;
    if (!rst_n_in) begin
      mode <= 2'h1;
      sel <= 16'h413d;
      rel <= 16'h00c8;
      app <= 16'h00c8;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 4'h0) sel <= reg_wdata_in;
      if (reg_addr_in == 4'h1) mode <= reg_wdata_in[1:0];
      if (reg_addr_in == 4'h2) rel <= reg_wdata_in;
      if (reg_addr_in == 4'h3) app <= reg_wdata_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_brake_direct: assert property (live && mode == 2'h1 && $stable(mode) |->
    pins_out.brake == $past(drive_enable_in)) else $error("brake pin off enable");
  chk_brake_invert: assert property (live && mode == 2'h2 && $stable(mode) |->
    pins_out.brake != $past(drive_enable_in)) else $error("brake pin not inverted");
  chk_torque_pin: assert property (live && $stable(sel) && sel[3:1] == 3'h4 |->
    pins_out.torque == ($past(motion_in.torque_reached) ^ sel[0])) else $error("torque pin");
  chk_velocity_pin: assert property (live && $stable(sel) && sel[7:5] == 3'h5 |->
    pins_out.pos_vel == ($past(motion_in.vel_reached) ^ sel[4])) else $error("velocity pin");
  chk_enabled_pin: assert property (live && $stable(sel) && sel[11:10] == 2'h0 &&
    sel[9] != sel[8] |-> pins_out.enabled == ($past(drive_enable_in) ^ sel[9]))
    else $error("enabled pin");
  chk_inpos_pin: assert property (live && $stable(sel) && sel[15:13] == 3'h2 |->
    pins_out.in_pos_tach == ($past(motion_in.in_position) ^ sel[12])) else $error("inpos pin");
  chk_release_wait: assert property ($rose(drive_enable_in) && mode == 2'h1 &&
    rel == 16'h0002 |-> !move_permit_out ##T_LO !move_permit_out ##[1:8] move_permit_out)
    else $error("release delay wrong");
  chk_apply_hold: assert property ($fell(drive_enable_in) && mode == 2'h1 &&
    app == 16'h0002 && move_permit_out |-> motor_current_on_out ##T_LO
    motor_current_on_out ##[1:8] !motor_current_on_out) else $error("apply delay wrong");
  chk_no_delay: assert property ($rose(drive_enable_in) && mode == 2'h3 &&
    $stable(mode) |-> ##[1:2] move_permit_out) else $error("delay outside modes 1 and 2");
  chk_permit_current: assert property (move_permit_out |-> motor_current_on_out)
    else $error("move permitted with current off");
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside read cycle");
  cov_release: cover property ($rose(move_permit_out));
  cov_apply: cover property ($fell(motor_current_on_out));
  cov_mode_two: cover property (mode == 2'h2 && drive_enable_in);
endmodule : sbf_checker
`default_nettype wire

// ### verification/sbf_io_model.sv
// Model of the machine wiring feeding the filtered input pins
`timescale 1ns/1ps
`default_nettype none
module sbf_io_model (
  input  wire logic       sys_clk_in,
  input  wire logic [3:0] level_in,
  output logic      [3:0] pin_out
);
  // Levels move just after an edge, as switch contacts seen by the sync stage
  always_ff @(posedge sys_clk_in) begin
    pin_out <= level_in;
  end
endmodule : sbf_io_model
`default_nettype wire

// ### verification/sbf_tb_top.sv
// Testbench top for the brake, output select and input filter block
`timescale 1ns/1ps
`default_nettype none
module sbf_tb_top;
  localparam int MS = 10;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] reg_rdata_out;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic drive_enable_in = 1'b0;
  sbf_pkg::sbf_motion_t motion_in = '0;
  sbf_pkg::sbf_pins_t pins_out;
  logic move_permit_out, motor_current_on_out, irq_out;
  logic [3:0] filtered_inputs_out, pin;
  logic [3:0] pin_req = 4'h0;
  logic [3:0] ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hc};
  logic [15:0] rv [6] = '{16'h413d, 16'h0001, 16'h00c8, 16'h00c8, 16'h0000, 16'h0000};
  logic [15:0] sv [4] = '{16'h4168, 16'h5279, 16'hc3b3, 16'h33a3};
  logic [4:0] pv [4] = '{5'h0b, 5'h04, 5'h01, 5'h05};
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  sbf_top #(.MS_CYCLES(MS), .TICK_CYCLES(5)) DUT (.sys_clk_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .drive_enable_in, .motion_in,
    .move_permit_out, .motor_current_on_out, .filtered_inputs_out,
    .filtered_input_a_in(pin[0]), .filtered_input_b_in(pin[1]), .filtered_input_c_in(pin[2]),
    .filtered_input_d_in(pin[3]), .pins_out, .irq_out);
  sbf_io_model u_far (.sys_clk_in, .level_in(pin_req), .pin_out(pin));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 cmp(reg_rdata_out, exp);
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  // Brake cycle in the current mode; moves wait out the release delay
  task automatic cycle_enable(input logic pin_on);
    @(posedge sys_clk_in) drive_enable_in <= 1'b1;
    step(2);
    cmp(pins_out.brake, pin_on);
    cmp(move_permit_out, 1'b0);
    step(24);
    cmp(move_permit_out, 1'b1);
    @(posedge sys_clk_in) drive_enable_in <= 1'b0;
    step(2);
    cmp(pins_out.brake, !pin_on);
    cmp(motor_current_on_out, 1'b1);
    step(24);
    cmp(motor_current_on_out, 1'b0);
  endtask : cycle_enable
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("test done: reset values");
    wr(4'h2, 16'h0002);
    wr(4'h3, 16'h0002);
    wr(4'hb, 16'h0030);
    cycle_enable(1'b1);
    cmp(irq_out, 1'b1);
    rd(4'ha, 16'h0030);
    cmp(irq_out, 1'b0);
    wr(4'h1, 16'h0002);
    cycle_enable(1'b0);
    $display("test done: brake modes 1 and 2");
    wr(4'h8, 16'h0001);
    wr(4'h1, 16'h0003);
    step(2);
    cmp(pins_out.brake, 1'b1);
    @(posedge sys_clk_in) drive_enable_in <= 1'b1;
    step(2);
    cmp(move_permit_out, 1'b1);
    $display("test done: brake mode 3");
    wr(4'h8, 16'h0010);
    motion_in <= 6'h2f;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, sv[i]);
      step(2);
      cmp(pins_out, pv[i]);
    end
    $display("test done: output select");
    wr(4'h5, 16'h0002);
    wr(4'h6, 16'h0006);
    wr(4'h7, 16'h0006);
    @(posedge sys_clk_in) pin_req <= 4'hf;
    step(8);
    cmp(filtered_inputs_out[0], 1'b1);
    @(posedge sys_clk_in) pin_req <= 4'hb;
    step(12);
    cmp(filtered_inputs_out, 4'h3);
    step(25);
    cmp(filtered_inputs_out, 4'hb);
    rd(4'h9, 16'h02fb);
    $display("test done: input filters");
    end_of_test();
  end
endmodule : sbf_tb_top
bind sbf_top sbf_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .drive_enable_in, .motion_in,
  .move_permit_out, .motor_current_on_out, .pins_out);
`default_nettype wire
